// >>> rtl/rrf_remote_reply.sv
// read-side remote register logic: fault snapshots and instruction replies
// assumes the drive core answers each issued instruction with a done pulse
`timescale 1ns/10ps
module rrf_remote_reply #(
  parameter int HIST_DEPTH = 8
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  // master side flags and words
  input wire logic i_instruction_execute_request,
  input wire logic i_freq_write_ram_request,
  input wire logic i_freq_write_nv_request,
  input wire logic [15:0] i_fault_history_selector,
  input wire logic [15:0] i_primary_instruction,
  input wire logic [15:0] i_queued_instruction_slot [rrf_pkg::NUM_SLOTS],
  input wire logic [7:0] i_reply_format_selector,
  output logic o_instruction_done_flag,
  // word read port
  input wire logic [7:0] i_read_word,
  output logic [15:0] o_read_data,
  // drive core: instruction execution
  output logic o_exec_start,
  output logic [15:0] o_exec_code,
  output logic [2:0] o_exec_slot,
  input wire logic i_exec_done,
  input wire logic [1:0] i_exec_result,
  input wire logic [15:0] i_exec_data,
  // drive core: command results
  input wire logic i_cmd_done,
  input wire logic [1:0] i_freq_result,
  input wire logic [1:0] i_torque_result,
  input wire logic i_torque_active,
  // fault history storage
  input wire logic [15:0] i_hist_freq [HIST_DEPTH],
  input wire logic [15:0] i_hist_curr [HIST_DEPTH],
  input wire logic [15:0] i_hist_volt [HIST_DEPTH],
  input wire logic [15:0] i_hist_time [HIST_DEPTH]
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  rrf_pkg::rrf_state_t state;
  logic [2:0] slot;
  logic [15:0] primary_instr_reply;
  logic [15:0] primary_read;
  logic [7:0] cmd_reply;
  logic [15:0] q_reply [rrf_pkg::NUM_SLOTS];
  logic [15:0] q_read [rrf_pkg::NUM_SLOTS];
  logic [15:0] snap [4];
  logic req_d;
  logic split;
  logic [15:0] enc_word;
  logic [2:0] next_slot;
  logic [15:0] cur_code;
  logic freq_req;
  logic req_edge;
  logic exec_fin;
  logic exec_ok;
  logic [15:0] next_read_data;

  assign split = (i_reply_format_selector != 8'h00);
  // either frequency request routes the command reply onto word 2
  assign freq_req = i_freq_write_ram_request || i_freq_write_nv_request;
  assign req_edge = i_instruction_execute_request && !req_d;
  assign exec_fin = (state == rrf_pkg::ST_WAIT) && i_exec_done;
  assign exec_ok = exec_fin && (i_exec_result == rrf_pkg::RES_NORMAL);

  function automatic logic [15:0] slot_code(input logic [2:0] s,
                                            input logic [15:0] p,
                                            input logic [15:0] q [rrf_pkg::NUM_SLOTS]);
    if (s == 3'h0) begin
      return p;
    end
    return q[s - 3'h1];
  endfunction : slot_code

  // ------------------------------------------------------------
  // word decode helpers
  // ------------------------------------------------------------
  // queued words come in pairs, reply then read data, one pair per slot
  function automatic logic [2:0] queue_index(input logic [7:0] w);
    logic [7:0] offs;
    offs = w - rrf_pkg::WORD_QUEUE_BASE;
    return offs[3:1];
  endfunction : queue_index

  function automatic logic word_in(input logic [7:0] w,
                                   input logic [7:0] lo,
                                   input logic [7:0] hi);
    return (w >= lo) && (w <= hi);
  endfunction : word_in

  // skip disabled queued slots
  always_comb begin
    next_slot = 3'h6;
    for (int k = rrf_pkg::NUM_SLOTS; k >= 1; k--) begin
      if (k > slot && i_queued_instruction_slot[k - 1] != rrf_pkg::CODE_DISABLED) begin
        next_slot = 3'(k);
      end
    end
  end

  assign cur_code = slot_code(slot, i_primary_instruction, i_queued_instruction_slot);

  rrf_reply_enc u_enc (
    .i_result(i_exec_result),
    .i_split(split),
    .o_word(enc_word)
  );

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      req_d <= 1'b0;
    end else begin
      req_d <= i_instruction_execute_request;
    end
  end

  // request edges seen outside idle are dropped, not queued
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      state <= rrf_pkg::ST_IDLE;
    end else begin
      case (state)
        rrf_pkg::ST_IDLE: begin
          if (req_edge) begin
            state <= rrf_pkg::ST_ISSUE;
          end
        end
        rrf_pkg::ST_ISSUE: state <= rrf_pkg::ST_WAIT;
        rrf_pkg::ST_WAIT: begin
          if (i_exec_done) begin
            if (next_slot > 3'(rrf_pkg::NUM_SLOTS)) begin
              state <= rrf_pkg::ST_DONE;
            end else begin
              state <= rrf_pkg::ST_ISSUE;
            end
          end
        end
        rrf_pkg::ST_DONE: state <= rrf_pkg::ST_IDLE;
        default: state <= rrf_pkg::ST_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // slot pointer and done flag
  // ------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      slot <= 3'h0;
    end else if (state == rrf_pkg::ST_IDLE && req_edge) begin
      slot <= 3'h0;
    end else if (exec_fin && next_slot <= 3'(rrf_pkg::NUM_SLOTS)) begin
      slot <= next_slot;
    end
  end

  // done flag stands until the master drops its request
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      o_instruction_done_flag <= 1'b0;
    end else if (state == rrf_pkg::ST_DONE) begin
      o_instruction_done_flag <= 1'b1;
    end else if (state == rrf_pkg::ST_IDLE
                 && (!i_instruction_execute_request || req_edge)) begin
      o_instruction_done_flag <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      o_exec_start <= 1'b0;
      o_exec_code <= rrf_pkg::RESET_WORD;
      o_exec_slot <= 3'h0;
    end else begin
      o_exec_start <= (state == rrf_pkg::ST_ISSUE);
      if (state == rrf_pkg::ST_ISSUE) begin
        o_exec_code <= cur_code;
        o_exec_slot <= slot;
      end
    end
  end

  // ------------------------------------------------------------
  // reply and read data capture
  // ------------------------------------------------------------
  // reply words take every result code, normal or not
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      primary_instr_reply <= rrf_pkg::RESET_WORD;
    end else if (exec_fin && slot == 3'h0) begin
      primary_instr_reply <= enc_word;
    end
  end

  // read data keeps its old value unless the instruction ended normally
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      primary_read <= rrf_pkg::RESET_WORD;
    end else if (exec_ok && slot == 3'h0) begin
      primary_read <= i_exec_data;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      for (int k = 0; k < rrf_pkg::NUM_SLOTS; k++) begin
        q_reply[k] <= rrf_pkg::RESET_WORD;
      end
    end else if (exec_fin && slot != 3'h0) begin
      q_reply[slot - 3'h1] <= enc_word;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      for (int k = 0; k < rrf_pkg::NUM_SLOTS; k++) begin
        q_read[k] <= rrf_pkg::RESET_WORD;
      end
    end else if (exec_ok && slot != 3'h0) begin
      q_read[slot - 3'h1] <= i_exec_data;
    end
  end

  // frequency / torque command reply byte
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      cmd_reply <= 8'h00;
    end else if (i_cmd_done && freq_req) begin
      if (i_torque_active && i_reply_format_selector != rrf_pkg::FMT_NO_TORQUE_A
          && i_reply_format_selector != rrf_pkg::FMT_NO_TORQUE_B) begin
        cmd_reply <= {2'h0, i_torque_result, 2'h0, i_freq_result};
      end else begin
        cmd_reply <= {6'h00, i_freq_result};
      end
    end
  end

  // ------------------------------------------------------------
  // fault snapshot, selector low byte beyond stored depth leaves it unchanged
  // ------------------------------------------------------------
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      for (int k = 0; k < 4; k++) begin
        snap[k] <= rrf_pkg::RESET_WORD;
      end
    end else begin
      for (int h = 0; h < HIST_DEPTH; h++) begin
        if (i_fault_history_selector[7:0] == 8'(h)) begin
          snap[0] <= i_hist_freq[h];
          snap[1] <= i_hist_curr[h];
          snap[2] <= i_hist_volt[h];
          snap[3] <= i_hist_time[h];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // word read mux, registered
  // ------------------------------------------------------------
  // unmapped words read as zero
  always_comb begin
    next_read_data = rrf_pkg::RESET_WORD;
    if (i_read_word == rrf_pkg::WORD_PRIMARY_REPLY) begin
      if (split) begin
        next_read_data = {primary_instr_reply[7:0], cmd_reply};
      end else if (freq_req) begin
        next_read_data = {14'h0000, cmd_reply[1:0]};
      end else begin
        next_read_data = primary_instr_reply;
      end
    end else if (i_read_word == rrf_pkg::WORD_PRIMARY_READ) begin
      next_read_data = primary_read;
    end else if (word_in(i_read_word, rrf_pkg::WORD_SNAP_FREQ, rrf_pkg::WORD_SNAP_TIME)) begin
      next_read_data = snap[2'(i_read_word - rrf_pkg::WORD_SNAP_FREQ)];
    end else if (word_in(i_read_word, rrf_pkg::WORD_QUEUE_BASE, rrf_pkg::WORD_QUEUE_LAST)) begin
      if (i_read_word[0]) begin
        next_read_data = q_read[queue_index(i_read_word)];
      end else begin
        next_read_data = q_reply[queue_index(i_read_word)];
      end
    end
  end

  // registered so the master sees a settled word one cycle after the select
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      o_read_data <= rrf_pkg::RESET_WORD;
    end else begin
      o_read_data <= next_read_data;
    end
  end
endmodule : rrf_remote_reply

// >>> rtl/rrf_pkg.sv
// constants for the remote reply and fault readout block
// assumes a single system clock and documented remote word numbering
// Operation
// - fault snapshot words follow history selector
// - execute request loads each enabled queued slot reply
// - zero reply normal, nonzero on failure
// - read data loaded only on normal completion
// - results go to words 2,10,12,14,16,18
// - normal coded H0000 or H00
// - write mode error coded H0001/H01
// - parameter selection error coded H0002/H02
// - setting range error coded H0003/H03
// - split format out-of-range command gives H03
// - selector zero 16-bit, else split bytes
// - torque upper nibble, frequency lower nibble
// - split: command low byte, instruction high
// - run primary then slots, then done flag
// - HFFFF disables queued slot; primary always runs
package rrf_pkg;
  // ------------------------------------------------------------
  // word numbers and codes
  // ------------------------------------------------------------
  localparam int NUM_SLOTS = 5;
  localparam logic [7:0] WORD_PRIMARY_REPLY = 8'h02;
  localparam logic [7:0] WORD_PRIMARY_READ = 8'h03;
  localparam logic [7:0] WORD_SNAP_FREQ = 8'h09;
  localparam logic [7:0] WORD_SNAP_CURR = 8'h0A;
  localparam logic [7:0] WORD_SNAP_VOLT = 8'h0B;
  localparam logic [7:0] WORD_SNAP_TIME = 8'h0C;
  localparam logic [7:0] WORD_QUEUE_BASE = 8'h10;
  localparam logic [7:0] WORD_QUEUE_LAST = 8'h19;
  localparam logic [15:0] CODE_DISABLED = 16'hFFFF;
  localparam logic [1:0] RES_NORMAL = 2'h0;
  localparam logic [1:0] RES_MODE_ERR = 2'h1;
  localparam logic [1:0] RES_SEL_ERR = 2'h2;
  localparam logic [1:0] RES_RANGE_ERR = 2'h3;
  localparam logic [7:0] FMT_NO_TORQUE_A = 8'h0E;
  localparam logic [7:0] FMT_NO_TORQUE_B = 8'h12;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  typedef enum {ST_IDLE, ST_ISSUE, ST_WAIT, ST_DONE} rrf_state_t;
endpackage : rrf_pkg

// >>> rtl/rrf_reply_enc.sv
// reply word encoder for one executed instruction
// assumes result codes from the drive core
`timescale 1ns/10ps
module rrf_reply_enc (
  input wire logic [1:0] i_result,
  input wire logic i_split,
  output logic [15:0] o_word
);
  // ------------------------------------------------------------
  // encode
  // ------------------------------------------------------------
  always_comb begin
    if (i_split) begin
      o_word = {14'h0000, i_result};
    end else begin
      o_word = {14'h0000, i_result};
    end
  end
endmodule : rrf_reply_enc

// >>> verif/rrf_core_model.sv
// drive core model: answers each issued instruction with one done pulse
// assumes the testbench sets core_res before each execute request
`timescale 1ns/10ps
module rrf_core_model (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic o_exec_start,
  input wire logic [15:0] o_exec_code,
  input wire logic [2:0] o_exec_slot,
  input wire logic [1:0] core_res [6],
  output logic i_exec_done,
  output logic [1:0] i_exec_result,
  output logic [15:0] i_exec_data
);
  logic [3:0] cnt;
  // later slots answer slower, so prompt and slow replies both occur
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      cnt <= 4'h0;
      i_exec_done <= 1'b0;
    end else begin
      i_exec_done <= (cnt == 4'h1);
      if (o_exec_start) begin
        cnt <= 4'h1 + {o_exec_slot, 1'b0};
      end else if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
  // outside the done pulse the lines carry inverted junk
  assign i_exec_result = i_exec_done ? core_res[o_exec_slot] : ~core_res[o_exec_slot];
  assign i_exec_data = i_exec_done ? (o_exec_code ^ 16'h5A5A) : ~o_exec_code;
endmodule : rrf_core_model

// >>> verif/rrf_remote_reply_asserts.sv
// checker for the remote reply block, bound to its top module
// assumes the fault history inputs are held steady
`timescale 1ns/10ps
module rrf_remote_reply_asserts #(
  parameter int HIST_DEPTH = 8
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic i_instruction_execute_request,
  input wire logic [15:0] i_fault_history_selector,
  input wire logic [15:0] i_queued_instruction_slot [rrf_pkg::NUM_SLOTS],
  input wire logic [7:0] i_read_word,
  input wire logic i_exec_done,
  input wire logic [15:0] i_hist_freq [HIST_DEPTH],
  input wire logic o_instruction_done_flag,
  input wire logic [15:0] o_read_data,
  input wire logic o_exec_start,
  input wire logic [15:0] o_exec_code,
  input wire logic [2:0] o_exec_slot
);
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  logic busy;
  logic req_q;
  logic [2:0] last_slot;
  always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
    if (I_RST) begin
      busy <= 1'b0;
      req_q <= 1'b0;
      last_slot <= 3'h0;
    end else begin
      req_q <= i_instruction_execute_request;
      if (i_instruction_execute_request && !req_q && !busy) begin
        busy <= 1'b1;
      end else if (o_instruction_done_flag) begin
        busy <= 1'b0;
      end
      if (o_exec_start) begin
        last_slot <= o_exec_slot;
      end
    end
  end
  sequence req_taken_s;
    $rose(i_instruction_execute_request) && !busy;
  endsequence
  sequence snap_held_s;
    (i_read_word == rrf_pkg::WORD_SNAP_FREQ && $stable(i_fault_history_selector)) [*2];
  endsequence
  start_latency_a: assert property (
    req_taken_s |-> ##2 (o_exec_start && o_exec_slot == 3'h0))
    else $error("first issue late or not slot zero");
  chain_issue_a: assert property (
    i_exec_done |-> ##2 (o_exec_start || o_instruction_done_flag))
    else $error("no issue or done two cycles after done pulse");
  start_pulse_a: assert property (o_exec_start |=> !o_exec_start)
    else $error("issue pulse longer than one cycle");
  slot_order_a: assert property (
    o_exec_start && o_exec_slot != 3'h0 |-> o_exec_slot > last_slot)
    else $error("queued slots out of order");
  slot_code_a: assert property (
    o_exec_start && o_exec_slot != 3'h0 |-> o_exec_code != rrf_pkg::CODE_DISABLED
    && o_exec_code == i_queued_instruction_slot[o_exec_slot - 3'h1])
    else $error("wrong or disabled code issued");
  done_hold_a: assert property (
    o_instruction_done_flag && i_instruction_execute_request |=> o_instruction_done_flag)
    else $error("done flag dropped while request high");
  done_clear_a: assert property (
    $fell(i_instruction_execute_request) |-> ##[1:2] !o_instruction_done_flag)
    else $error("done flag not cleared");
  snap_read_a: assert property (
    snap_held_s |=> o_read_data == i_hist_freq[i_fault_history_selector[7:0]])
    else $error("snapshot frequency word wrong");
  unmapped_zero_a: assert property (
    i_read_word == 8'h05 |=> o_read_data == 16'h0000)
    else $error("unmapped word not zero");
endmodule : rrf_remote_reply_asserts
bind rrf_remote_reply rrf_remote_reply_asserts #(.HIST_DEPTH(HIST_DEPTH)) u_chk (.*);

// >>> verif/remote_reply_and_fault_readout_tb_top.sv
// self-checking bench for the remote reply block
// assumes rrf_pkg, the core model and the checker are compiled first
`timescale 1ns/10ps
module remote_reply_and_fault_readout_tb_top;
  localparam int HD = 8;
  logic I_CLK_SYS = 1'b0;
  logic I_RST = 1'b1;
  logic i_instruction_execute_request = 1'b0;
  logic i_freq_write_ram_request = 1'b0;
  logic i_freq_write_nv_request = 1'b0;
  logic [15:0] i_fault_history_selector = 16'h0000;
  logic [15:0] i_primary_instruction = 16'h0200;
  logic [15:0] i_queued_instruction_slot [rrf_pkg::NUM_SLOTS];
  logic [7:0] i_reply_format_selector = 8'h00;
  logic [7:0] i_read_word = 8'h00;
  logic i_cmd_done = 1'b0;
  logic [1:0] i_freq_result = 2'h0;
  logic [1:0] i_torque_result = 2'h0;
  logic i_torque_active = 1'b0;
  logic [15:0] i_hist_freq [HD];
  logic [15:0] i_hist_curr [HD];
  logic [15:0] i_hist_volt [HD];
  logic [15:0] i_hist_time [HD];
  logic o_instruction_done_flag, o_exec_start, i_exec_done;
  logic [15:0] o_read_data, o_exec_code, i_exec_data;
  logic [2:0] o_exec_slot;
  logic [1:0] i_exec_result;
  logic [1:0] core_res [6];
  logic [15:0] exp_rep [6];
  logic [15:0] exp_dat [6];
  int error_cnt = 0;
  int num_checks = 0;
  always #4 I_CLK_SYS = ~I_CLK_SYS;
  rrf_remote_reply #(.HIST_DEPTH(HD)) uut (.*);
  rrf_core_model u_core (.*);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("ERROR %0t got %h exp %h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk
  task automatic rd(input logic [7:0] w, input logic [15:0] exp);
    @(posedge I_CLK_SYS);
    i_read_word <= w;
    repeat (2) @(posedge I_CLK_SYS);
    #1 chk(o_read_data, exp);
  endtask : rd
  task automatic cmd(input logic [7:0] fmt);
    @(posedge I_CLK_SYS);
    i_reply_format_selector <= fmt;
    i_freq_write_ram_request <= 1'b1;
    i_cmd_done <= 1'b1;
    @(posedge I_CLK_SYS);
    i_cmd_done <= 1'b0;
    i_freq_write_ram_request <= 1'b0;
  endtask : cmd
  // queued slot k carries code 0310+k unless its off bit is set
  task automatic run(input logic [4:0] off, input logic [11:0] res);
    int k;
    for (k = 0; k < 6; k++) core_res[k] = res[2*k +: 2];
    @(posedge I_CLK_SYS);
    for (k = 0; k < 5; k++) i_queued_instruction_slot[k] <= off[k] ? 16'hFFFF : 16'h0310 + 16'(k);
    i_instruction_execute_request <= 1'b1;
    for (k = 0; k < 300 && o_instruction_done_flag !== 1'b1; k++) @(posedge I_CLK_SYS);
    chk({15'h0, o_instruction_done_flag}, 16'h0001);
    i_instruction_execute_request <= 1'b0;
    for (k = 0; k < 6; k++) begin
      if (k == 0 || !off[k-1]) begin
        exp_rep[k] = {14'h0, res[2*k +: 2]};
        if (res[2*k +: 2] == 2'h0) exp_dat[k] = (k == 0 ? 16'h0200 : 16'h030F + 16'(k)) ^ 16'h5A5A;
      end
    end
    rd(8'h03, exp_dat[0]);
    for (k = 1; k < 6; k++) begin
      rd(8'h0E + 8'(2*k), exp_rep[k]);
      rd(8'h0F + 8'(2*k), exp_dat[k]);
    end
    chk({15'h0, o_instruction_done_flag}, 16'h0000);
  endtask : run
  task automatic results();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results
  initial begin
    repeat (20000) @(posedge I_CLK_SYS);
    error_cnt++;
    results();
  end
  initial begin
    for (int k = 0; k < HD; k++) begin
      i_hist_freq[k] = 16'h1000 + 16'(k);
      i_hist_curr[k] = 16'h2000 + 16'(k);
      i_hist_volt[k] = 16'h3000 + 16'(k);
      i_hist_time[k] = 16'h4000 + 16'(k);
    end
    for (int k = 0; k < 6; k++) {core_res[k], exp_rep[k], exp_dat[k]} = 34'h0;
    for (int k = 0; k < 5; k++) i_queued_instruction_slot[k] = 16'hFFFF;
    repeat (12) @(posedge I_CLK_SYS);
    I_RST <= 1'b0;
    for (int s = 0; s < HD; s += HD - 1) begin
      @(posedge I_CLK_SYS);
      i_fault_history_selector <= 16'(s);
      for (int w = 0; w < 4; w++) rd(8'h09 + 8'(w), 16'h1000 * 16'(w + 1) + 16'(s));
    end
    rd(8'h05, 16'h0000);
    // every code in the 16-bit format, slot two skipped
    run(5'b00010, 12'h384);
    rd(8'h02, 16'h0000);
    @(posedge I_CLK_SYS);
    i_freq_write_nv_request <= 1'b1;
    i_freq_result <= 2'h2;
    i_cmd_done <= 1'b1;
    @(posedge I_CLK_SYS);
    i_cmd_done <= 1'b0;
    rd(8'h02, 16'h0002);
    @(posedge I_CLK_SYS);
    i_freq_write_nv_request <= 1'b0;
    rd(8'h02, 16'h0000);
    // split format with a frequency command out of range
    @(posedge I_CLK_SYS);
    i_torque_active <= 1'b1;
    i_torque_result <= 2'h1;
    i_freq_result <= 2'h3;
    cmd(8'h01);
    run(5'b10001, 12'h063);
    rd(8'h02, 16'h0313);
    cmd(rrf_pkg::FMT_NO_TORQUE_B);
    rd(8'h02, 16'h0303);
    cmd(rrf_pkg::FMT_NO_TORQUE_A);
    rd(8'h02, 16'h0303);
    results();
  end
endmodule : remote_reply_and_fault_readout_tb_top
